// *** tocps_pkg.sv ***
package tocps_pkg;

  // Register addresses on the plain port
  localparam logic [15:0] ADDR_RUN_MODE  = 16'hFFB0;
  localparam logic [15:0] ADDR_CMP0_LO   = 16'hFFB2;
  localparam logic [15:0] ADDR_CMP0_HI   = 16'hFFB3;
  localparam logic [15:0] ADDR_CMP1_LO   = 16'hFFB4;
  localparam logic [15:0] ADDR_CMP1_HI   = 16'hFFB5;
  localparam logic [15:0] ADDR_COUNT_LO  = 16'hFFB6;
  localparam logic [15:0] ADDR_COUNT_HI  = 16'hFFB7;
  localparam logic [15:0] ADDR_CLK_EDGE  = 16'hFFBB;
  localparam logic [15:0] ADDR_OUT_CTRL  = 16'hFFBD;

  // Reset values
  localparam logic [7:0]  OUT_CTRL_RST   = 8'h00;
  localparam logic [7:0]  CLK_EDGE_RST   = 8'h00;
  localparam logic [1:0]  RUN_MODE_RST   = 2'h0;
  localparam logic [15:0] CMP_RST        = 16'h0000;
  localparam logic [7:0]  READ_UNMAPPED  = 8'h00;

  // Output control register fields
  localparam int OC_OUT_EN      = 0;
  localparam int OC_CMP0_INV    = 1;
  localparam int OC_LVL_RESET   = 2;
  localparam int OC_LVL_SET     = 3;
  localparam int OC_CMP1_INV    = 4;
  localparam int OC_ONE_SHOT_EN = 5;
  localparam int OC_SW_TRIGGER  = 6;

  // Count clock / edge select register fields
  localparam int CE_CLK_SEL_LSB = 0;
  localparam int CE_IN0_ES_LSB  = 4;
  localparam int CE_IN1_ES_LSB  = 6;

  // Run modes
  localparam logic [1:0] MODE_STOP      = 2'h0;
  localparam logic [1:0] MODE_FREE      = 2'h1;
  localparam logic [1:0] MODE_EDGE_CLR  = 2'h2;
  localparam logic [1:0] MODE_MATCH_CLR = 2'h3;

  // Valid edge encodings
  localparam logic [1:0] EDGE_FALL      = 2'h0;
  localparam logic [1:0] EDGE_RISE      = 2'h1;
  localparam logic [1:0] EDGE_BOTH      = 2'h3;

  // Count clock sources
  localparam logic [2:0] CLK_PERIPH     = 3'h0;
  localparam logic [2:0] CLK_DIV2       = 3'h1;
  localparam logic [2:0] CLK_DIV4       = 3'h2;
  localparam logic [2:0] CLK_DIV16      = 3'h3;
  localparam logic [2:0] CLK_DIV256     = 3'h4;
  localparam logic [2:0] CLK_SUB        = 3'h5;
  localparam logic [2:0] CLK_IN0_EDGE   = 3'h6;
  localparam logic [2:0] CLK_AUX_TIMER  = 3'h7;

  // Divider terminal patterns
  localparam logic [7:0] DIV2_MASK      = 8'h01;
  localparam logic [7:0] DIV4_MASK      = 8'h03;
  localparam logic [7:0] DIV16_MASK     = 8'h0F;
  localparam logic [7:0] DIV256_MASK    = 8'hFF;

  typedef enum logic [1:0] {
    TOCPS_OS_IDLE,
    TOCPS_OS_WAIT1,
    TOCPS_OS_WAIT0
  } tocps_os_t;

endpackage

// *** tocps_edge.sv ***
module tocps_edge (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Asynchronous input and its edge choice
  input  wire logic       pin,
  input  wire logic       prime_low,
  input  wire logic [1:0] edge_sel,
  // Valid edge, one cycle; with rise or both selected, held high while prime_low and the pin stay high
  output logic            edge_pulse
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic rise;
  logic fall;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
    end
  end

  // Held low before first start so a high pin looks like a rise
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg <= 1'b0;
    end else if (prime_low) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  always_comb begin
    case (edge_sel)
      tocps_pkg::EDGE_FALL: edge_pulse = fall;
      tocps_pkg::EDGE_RISE: edge_pulse = rise;
      tocps_pkg::EDGE_BOTH: edge_pulse = rise | fall;
      default:              edge_pulse = 1'b0;
    endcase
  end

endmodule

// *** tocps_timer.sv ***
module tocps_timer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // External count sources
  input  wire logic        edge_in0,
  input  wire logic        sub_clk,
  input  wire logic        aux_8bit_timer,
  // Shared pin: second input and timer output
  input  wire logic        shared_pin_i,
  output logic             shared_pin_o,
  output logic             shared_pin_oe,
  // Status
  output logic             timer_output,
  output logic             match0_irq,
  output logic             match1_irq,
  output logic      [15:0] count_reg
);

  logic [7:0]  out_ctrl_reg;
  logic [7:0]  clk_edge_reg;
  logic [1:0]  run_mode_reg;
  logic [15:0] cmp_cap0;
  logic [15:0] cmp_cap1;
  logic [7:0]  div_reg;
  logic        ever_ran_reg;
  logic        to_reg;
  logic        m0_reg;
  logic        m1_reg;
  tocps_pkg::tocps_os_t os_reg;
  tocps_pkg::tocps_os_t os_next;

  logic        running;
  logic        out_en;
  logic        cmp0_inv;
  logic        cmp1_inv;
  logic        one_shot_en;
  logic [2:0]  clk_sel;
  logic [1:0]  in0_es;
  logic [1:0]  in1_es;
  logic        wr_oc;
  logic        sw_trig;
  logic        lvl_set;
  logic        lvl_rst;
  logic        in0_edge;
  logic        in1_edge;
  logic        sub_rise;
  logic        aux_rise;
  logic        tick;
  logic        restart;
  logic        hit0;
  logic        hit1;
  logic        tog0;
  logic        tog1;
  logic        os_mode;

  assign running     = run_mode_reg != tocps_pkg::MODE_STOP;
  assign out_en      = out_ctrl_reg[tocps_pkg::OC_OUT_EN];
  assign cmp0_inv    = out_ctrl_reg[tocps_pkg::OC_CMP0_INV];
  assign cmp1_inv    = out_ctrl_reg[tocps_pkg::OC_CMP1_INV];
  assign one_shot_en = out_ctrl_reg[tocps_pkg::OC_ONE_SHOT_EN];
  assign clk_sel     = clk_edge_reg[tocps_pkg::CE_CLK_SEL_LSB +: 3];
  assign in0_es      = clk_edge_reg[tocps_pkg::CE_IN0_ES_LSB +: 2];
  assign in1_es      = clk_edge_reg[tocps_pkg::CE_IN1_ES_LSB +: 2];

  // Write decodes for output control triggers
  assign wr_oc   = reg_wr && (reg_addr == tocps_pkg::ADDR_OUT_CTRL);
  assign sw_trig = wr_oc && reg_wdata[tocps_pkg::OC_SW_TRIGGER];
  assign lvl_set = wr_oc && reg_wdata[tocps_pkg::OC_LVL_SET];
  assign lvl_rst = wr_oc && reg_wdata[tocps_pkg::OC_LVL_RESET];

  // Input edge detectors, all inputs synchronised
  tocps_edge u_in0 (
    .clk        (clk),
    .rst_b      (rst_b),
    .pin        (edge_in0),
    .prime_low  (~(ever_ran_reg | running)),
    .edge_sel   (in0_es),
    .edge_pulse (in0_edge)
  );

  tocps_edge u_in1 (
    .clk        (clk),
    .rst_b      (rst_b),
    .pin        (shared_pin_i),
    .prime_low  (~(ever_ran_reg | running)),
    .edge_sel   (in1_es),
    .edge_pulse (in1_edge)
  );

  tocps_edge u_sub (
    .clk        (clk),
    .rst_b      (rst_b),
    .pin        (sub_clk),
    .prime_low  (1'b0),
    .edge_sel   (tocps_pkg::EDGE_RISE),
    .edge_pulse (sub_rise)
  );

  tocps_edge u_aux (
    .clk        (clk),
    .rst_b      (rst_b),
    .pin        (aux_8bit_timer),
    .prime_low  (1'b0),
    .edge_sel   (tocps_pkg::EDGE_RISE),
    .edge_pulse (aux_rise)
  );

  // Run mode register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_mode_reg <= tocps_pkg::RUN_MODE_RST;
    end else if (reg_wr && reg_addr == tocps_pkg::ADDR_RUN_MODE) begin
      run_mode_reg <= reg_wdata[1:0];
    end
  end

  // First start since reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ever_ran_reg <= 1'b0;
    end else if (running) begin
      ever_ran_reg <= 1'b1;
    end
  end

  // Compare registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_cap0 <= tocps_pkg::CMP_RST;
      cmp_cap1 <= tocps_pkg::CMP_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        tocps_pkg::ADDR_CMP0_LO: cmp_cap0[7:0]  <= reg_wdata;
        tocps_pkg::ADDR_CMP0_HI: cmp_cap0[15:8] <= reg_wdata;
        tocps_pkg::ADDR_CMP1_LO: cmp_cap1[7:0]  <= reg_wdata;
        tocps_pkg::ADDR_CMP1_HI: cmp_cap1[15:8] <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Count clock / edge select register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_edge_reg <= tocps_pkg::CLK_EDGE_RST;
    end else if (reg_wr && reg_addr == tocps_pkg::ADDR_CLK_EDGE) begin
      clk_edge_reg <= {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
    end
  end

  // Output control; trigger bits are not stored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_ctrl_reg <= tocps_pkg::OUT_CTRL_RST;
    end else if (wr_oc) begin
      out_ctrl_reg <= {3'h0, reg_wdata[4], 2'h0, reg_wdata[1:0]} |
                      {2'h0, reg_wdata[5], 5'h00};
    end
  end

  // Prescaler divider, cleared while stopped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 8'h00;
    end else if (!running) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // Count clock source select
  always_comb begin
    case (clk_sel)
      tocps_pkg::CLK_PERIPH:
        tick = 1'b1;
      tocps_pkg::CLK_DIV2:
        tick = (div_reg & tocps_pkg::DIV2_MASK) == tocps_pkg::DIV2_MASK;
      tocps_pkg::CLK_DIV4:
        tick = (div_reg & tocps_pkg::DIV4_MASK) == tocps_pkg::DIV4_MASK;
      tocps_pkg::CLK_DIV16:
        tick = (div_reg & tocps_pkg::DIV16_MASK) == tocps_pkg::DIV16_MASK;
      tocps_pkg::CLK_DIV256:
        tick = div_reg == tocps_pkg::DIV256_MASK;
      tocps_pkg::CLK_SUB:
        tick = sub_rise;
      tocps_pkg::CLK_IN0_EDGE:
        tick = in0_edge;
      tocps_pkg::CLK_AUX_TIMER:
        tick = aux_rise;
      default:
        tick = 1'b0;
    endcase
  end

  // Clear & start on input-0 edge in edge-clear mode, or on software trigger in any running mode
  assign restart = running &&
                   ((run_mode_reg == tocps_pkg::MODE_EDGE_CLR && in0_edge) ||
                    sw_trig);

  assign hit0 = running && tick && (count_reg == cmp_cap0);
  assign hit1 = running && tick && (count_reg == cmp_cap1);

  // Counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= 16'h0000;
    end else if (!running) begin
      count_reg <= 16'h0000;
    end else if (restart) begin
      count_reg <= 16'h0000;
    end else if (hit0 && run_mode_reg == tocps_pkg::MODE_MATCH_CLR) begin
      count_reg <= 16'h0000;
    end else if (tick) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // Match pulses raised whatever the inversion enables
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      m0_reg <= 1'b0;
      m1_reg <= 1'b0;
    end else begin
      m0_reg <= hit0;
      m1_reg <= hit1;
    end
  end

  assign match0_irq = m0_reg;
  assign match1_irq = m1_reg;

  // One-shot applies outside compare-0 clear mode
  assign os_mode = one_shot_en && (run_mode_reg != tocps_pkg::MODE_MATCH_CLR);

  always_comb begin
    os_next = os_reg;
    case (os_reg)
      tocps_pkg::TOCPS_OS_IDLE: begin
        if (restart) begin
          os_next = tocps_pkg::TOCPS_OS_WAIT1;
        end
      end
      tocps_pkg::TOCPS_OS_WAIT1: begin
        if (restart) begin
          os_next = tocps_pkg::TOCPS_OS_WAIT1;
        end else if (hit1) begin
          os_next = tocps_pkg::TOCPS_OS_WAIT0;
        end
      end
      tocps_pkg::TOCPS_OS_WAIT0: begin
        if (restart) begin
          os_next = tocps_pkg::TOCPS_OS_WAIT1;
        end else if (hit0) begin
          os_next = tocps_pkg::TOCPS_OS_IDLE;
        end
      end
      default: begin
        os_next = tocps_pkg::TOCPS_OS_IDLE;
      end
    endcase
    if (!running || !os_mode) begin
      os_next = tocps_pkg::TOCPS_OS_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      os_reg <= tocps_pkg::TOCPS_OS_IDLE;
    end else begin
      os_reg <= os_next;
    end
  end

  // Toggle requests, gated by one-shot progress
  always_comb begin
    if (os_mode) begin
      tog1 = hit1 && cmp1_inv && (os_reg == tocps_pkg::TOCPS_OS_WAIT1) && !restart;
      tog0 = hit0 && cmp0_inv && (os_reg == tocps_pkg::TOCPS_OS_WAIT0) && !restart;
    end else begin
      tog1 = hit1 && cmp1_inv;
      tog0 = hit0 && cmp0_inv;
    end
  end

  // Output level; a lone level set or reset wins over toggles, both together are ignored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      to_reg <= 1'b0;
    end else if (lvl_set && !lvl_rst) begin
      to_reg <= 1'b1;
    end else if (lvl_rst && !lvl_set) begin
      to_reg <= 1'b0;
    end else if (tog0 ^ tog1) begin
      to_reg <= ~to_reg;
    end
  end

  assign timer_output  = out_en & to_reg;
  assign shared_pin_o  = timer_output;
  assign shared_pin_oe = out_en;

  // Read data one cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= tocps_pkg::READ_UNMAPPED;
    end else if (reg_rd) begin
      case (reg_addr)
        tocps_pkg::ADDR_RUN_MODE: reg_rdata <= {6'h00, run_mode_reg};
        tocps_pkg::ADDR_CMP0_LO:  reg_rdata <= cmp_cap0[7:0];
        tocps_pkg::ADDR_CMP0_HI:  reg_rdata <= cmp_cap0[15:8];
        tocps_pkg::ADDR_CMP1_LO:  reg_rdata <= cmp_cap1[7:0];
        tocps_pkg::ADDR_CMP1_HI:  reg_rdata <= cmp_cap1[15:8];
        tocps_pkg::ADDR_COUNT_LO: reg_rdata <= count_reg[7:0];
        tocps_pkg::ADDR_COUNT_HI: reg_rdata <= count_reg[15:8];
        tocps_pkg::ADDR_CLK_EDGE: reg_rdata <= clk_edge_reg;
        tocps_pkg::ADDR_OUT_CTRL: reg_rdata <= out_ctrl_reg;
        default:                  reg_rdata <= tocps_pkg::READ_UNMAPPED;
      endcase
    end else begin
      reg_rdata <= tocps_pkg::READ_UNMAPPED;
    end
  end

endmodule

// *** tocps_timer_assertions.sv ***
module tocps_timer_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // Pin and status
  input wire logic        shared_pin_o,
  input wire logic        shared_pin_oe,
  input wire logic        timer_output,
  input wire logic        match0_irq,
  input wire logic        match1_irq,
  input wire logic [15:0] count_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stop_reg;
  wire  mode_wr = reg_wr && reg_addr == tocps_pkg::ADDR_RUN_MODE;
  wire  oc_wr   = reg_wr && reg_addr == tocps_pkg::ADDR_OUT_CTRL;

  // Shadow of the stopped state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_reg <= 1'b1;
    end else if (mode_wr) begin
      stop_reg <= reg_wdata[1:0] == tocps_pkg::MODE_STOP;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  out_low_a: assert property (!shared_pin_oe |-> !timer_output)
    else $error("timer output high while disabled");
  oe_off_a: assert property (oc_wr && !reg_wdata[0] |=> !shared_pin_oe)
    else $error("output enable not cleared");
  pin_drive_a: assert property (shared_pin_o == timer_output)
    else $error("pin drive differs from timer output");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  oc_read_a: assert property (reg_rd && reg_addr == tocps_pkg::ADDR_OUT_CTRL
    |=> (reg_rdata & 8'hCC) == 8'h00)
    else $error("trigger bits read nonzero");
  lvl_set_a: assert property (oc_wr && shared_pin_oe && reg_wdata[0]
    && reg_wdata[3:2] == 2'b10 |-> ##[1:2] timer_output)
    else $error("level set did not raise output");
  lvl_rst_a: assert property (oc_wr && reg_wdata[3:2] == 2'b01
    |-> ##[1:2] !timer_output)
    else $error("level reset did not lower output");
  stop_clear_a: assert property (stop_reg && $past(stop_reg) |-> count_reg == 16'h0000)
    else $error("counter not clear while stopped");
  stop_quiet_a: assert property (stop_reg && $past(stop_reg)
    |-> !match0_irq && !match1_irq)
    else $error("match pulse while stopped");
  m0_pulse_a: assert property (match0_irq |=> !match0_irq)
    else $error("match pulse longer than one cycle");
endmodule

bind tocps_timer tocps_timer_chk u_chk (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .shared_pin_o(shared_pin_o), .shared_pin_oe(shared_pin_oe),
  .timer_output(timer_output), .match0_irq(match0_irq), .match1_irq(match1_irq),
  .count_reg(count_reg));

// *** tocps_pins.sv ***
module tocps_pins (
  // Clock
  input  wire logic clk,
  // Timer side of the shared pin
  input  wire logic pin_o,
  input  wire logic pin_oe,
  // Lines toward the timer
  output logic      edge_in0,
  output logic      sub_clk,
  output logic      aux_8bit_timer,
  output logic      shared_pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] div_reg = 4'h0;
  logic       in1_ext = 1'b0;

  initial edge_in0 = 1'b0;
  always_ff @(posedge clk) div_reg <= div_reg + 4'h1;
  assign sub_clk        = div_reg[2];
  assign aux_8bit_timer = div_reg[3];
  // Only one user of the line at a time
  assign shared_pin_i = pin_oe ? pin_o : in1_ext;

  task automatic set0(input logic v);
    @(posedge clk);
    edge_in0 <= v;
  endtask

  // Each level held three cycles
  task automatic pulse0(input int n);
    repeat (n) begin
      set0(1'b1);
      repeat (2) @(posedge clk);
      set0(1'b0);
      repeat (2) @(posedge clk);
    end
  endtask
endmodule

// *** tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] RM = tocps_pkg::ADDR_RUN_MODE;
  localparam logic [15:0] OC = tocps_pkg::ADDR_OUT_CTRL;
  localparam logic [15:0] CE = tocps_pkg::ADDR_CLK_EDGE;
  `define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
  logic        clk, rst_b, wr, rd, e0, sc, ax, pi, po, poe, tout, m0, m1;
  logic [15:0] addr, cnt;
  logic [7:0]  wd, rdat;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          t, p0, p1;

  tocps_timer uut (.clk(clk), .rst_b(rst_b), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .edge_in0(e0), .sub_clk(sc),
    .aux_8bit_timer(ax), .shared_pin_i(pi), .shared_pin_o(po), .shared_pin_oe(poe),
    .timer_output(tout), .match0_irq(m0), .match1_irq(m1), .count_reg(cnt));
  tocps_pins pins (.clk(clk), .pin_o(po), .pin_oe(poe), .edge_in0(e0), .sub_clk(sc),
    .aux_8bit_timer(ax), .shared_pin_i(pi));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic report_and_stop;
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop;
    end
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wrr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(n, e, rdat)
  endtask

  task automatic run(input logic [1:0] m);
    wrr(RM, {6'h00, m});
  endtask

  // Write output control, then look at the output
  task automatic wck(input logic [7:0] d, input logic e, input string n);
    wrr(OC, d);
    wt(2);
    #1 `CHK(n, e, tout)
  endtask

  // Count output changes and match pulses
  task automatic watch(input int n);
    logic last;
    t = 0;
    p0 = 0;
    p1 = 0;
    @(posedge clk);
    #1 last = tout;
    repeat (n) begin
      @(posedge clk);
      #1 t += int'(tout !== last);
      p0 += int'(m0 === 1'b1);
      p1 += int'(m1 === 1'b1);
      last = tout;
    end
  endtask

  task automatic t_rst;
    rdc(OC, 8'h00, "oc reset");
    rdc(CE, 8'h00, "ce reset");
    rdc(16'hFFBF, tocps_pkg::READ_UNMAPPED, "unmapped");
    wrr(CE, 8'hFF);
    rdc(CE, 8'hF7, "ce rw");
  endtask

  task automatic t_oc;
    wck(8'h12, 1'b0, "inv only");
    wck(8'h13, 1'b0, "oe on");
    wck(8'h1B, 1'b1, "lvl set");
    rdc(OC, 8'h13, "lvl read");
    wck(8'h13, 1'b1, "lvl clear");
    wck(8'h17, 1'b0, "lvl reset");
    wck(8'h1B, 1'b1, "lvl set2");
    wck(8'h12, 1'b0, "oe off");
    wck(8'h13, 1'b1, "oe back");
  endtask

  task automatic t_clk;
    logic [15:0] c;
    int ex[8] = '{512, 256, 128, 32, 2, 64, 0, 32};
    for (int s = 0; s < 8; s++) begin
      if (s != 6) begin
        run(2'h0);
        wt(1);
        #1 `CHK("stop clear", 16'h0000, cnt)
        wrr(CE, {5'h00, s[2:0]});
        run(2'h1);
        wt(4);
        #1 c = cnt;
        wt(512);
        #1 `CHK("rate", ex[s][15:0], cnt - c)
      end
    end
  endtask

  task automatic t_match;
    run(2'h0);
    wrr(CE, 8'h00);
    wrr(tocps_pkg::ADDR_CMP0_LO, 8'h04);
    wrr(tocps_pkg::ADDR_CMP1_LO, 8'h02);
    wrr(OC, 8'h02);
    wrr(OC, 8'h03);
    run(2'h3);
    watch(50);
    `CHK("m0 count", 10, p0)
    `CHK("m1 count", 10, p1)
    `CHK("cmp0 toggles", 10, t)
    wrr(OC, 8'h13);
    watch(50);
    `CHK("both toggles", 20, t)
  endtask

  task automatic t_shot;
    run(2'h0);
    wrr(tocps_pkg::ADDR_CMP0_LO, 8'h06);
    wrr(tocps_pkg::ADDR_CMP1_LO, 8'h03);
    wrr(OC, 8'h32);
    wrr(OC, 8'h33);
    wrr(OC, 8'h37);
    run(2'h1);
    repeat (2) begin
      wrr(OC, 8'h73);
      #1 `CHK("restart", 1'b1, cnt < 16'h0004)
      watch(100);
      `CHK("shot toggles", 2, t)
    end
    rdc(OC, 8'h33, "trig read");
  endtask

  task automatic t_edge;
    logic [15:0] c;
    int ex[4] = '{4, 4, 0, 8};
    for (int e = 0; e < 4; e++) begin
      run(2'h0);
      wrr(CE, {2'b00, e[1:0], 4'h6});
      run(2'h1);
      wt(4);
      #1 c = cnt;
      pins.pulse0(4);
      wt(6);
      #1 `CHK("edges", ex[e][15:0], cnt - c)
    end
  endtask

  task automatic t_prime;
    pins.set0(1'b1);
    rst_b <= 1'b0;
    wt(12);
    rst_b <= 1'b1;
    wrr(CE, 8'h16);
    run(2'h1);
    wt(6);
    #1 `CHK("prime", 16'h0001, cnt)
    run(2'h0);
    run(2'h1);
    wt(6);
    #1 `CHK("no prime", 16'h0000, cnt)
  endtask

  initial begin
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wd = 8'h00;
    wt(12);
    rst_b <= 1'b1;
    t_rst;
    t_oc;
    t_clk;
    t_match;
    t_shot;
    t_edge;
    t_prime;
    report_and_stop;
  end
endmodule
